/* File: verification/spi_slave_model.sv */
// Behavioural external slave facing the core when it acts as master
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model
(
  // Pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel,
  output logic miso,
  // Observed byte
  output logic [7:0] got
);
  logic [7:0] tx;
  task automatic preload(input logic [7:0] v);
    tx = v;
  endtask
  // Mode 0: sample on rising edge, shift on falling edge
  always @(posedge sck)
  begin
    got = {got[6:0], mosi};
  end
  always @(negedge sck)
  begin
    if (sel)
      tx = {tx[6:0], 1'b0};
  end
  // Released line shows the inverse so a stale sample cannot match
  assign miso = sel ? tx[7] : ~tx[7];
endmodule // spi_slave_model
`default_nettype wire

/* File: verification/test_spi_core_slave_select.sv */
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module test_spi_core_slave_select;
  logic sys_clk, reset, ctrl_write, soft_mode, soft_level, ss_pin_n;
  logic status_read, data_write, data_read, slave_sel, irq, part_miso;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic [7:0] data_wdata, data_rdata, got;
  spi_core_pkg::ctrl_t ctrl_wdata, ctrl;
  spi_core_pkg::flags_t flags;
  wire sck_w, mosi_w, miso_w;
  int errors = 0;
  int check_count = 0;
  int n;
  // Idle clock pulled low; undriven mosi toggles, undriven miso follows the slave model
  assign sck_w = sck_oe ? sck_out : 1'b0;
  assign mosi_w = mosi_oe ? mosi_out : sys_clk;
  assign miso_w = miso_oe ? miso_out : part_miso;
  spi_core_slave_select spi_core_slave_select_inst (.sys_clk(sys_clk),
    .reset(reset), .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata),
    .slave_select_soft_mode(soft_mode), .slave_select_soft_level(soft_level),
    .status_read(status_read), .data_write(data_write),
    .data_read(data_read), .data_wdata(data_wdata), .data_rdata(data_rdata),
    .flags(flags), .ctrl(ctrl), .irq(irq), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_pin_n(ss_pin_n));
  spi_slave_model spi_slave_model_inst (.sck(sck_w), .mosi(mosi_w),
    .sel(slave_sel), .miso(part_miso), .got(got));
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #10;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cfg(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_write = 1'b1;
    step(1);
    ctrl_write = 1'b0;
  endtask
  task automatic write_byte(input logic [7:0] v);
    data_wdata = v;
    data_write = 1'b1;
    step(1);
    data_write = 1'b0;
  endtask
  task automatic clear_done();
    status_read = 1'b1;
    step(1);
    status_read = 1'b0;
    data_read = 1'b1;
    step(1);
    data_read = 1'b0;
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset();
    chk(ctrl, 8'h00);
    chk({4'h0, flags}, 8'h00);
    chk({4'h0, sck_oe, mosi_oe, miso_oe, irq}, 8'h00);
  endtask
  // Master byte at /8, a colliding write, and a write blocked by done
  task automatic t_master();
    cfg(8'he1);
    spi_slave_model_inst.preload(8'h3c);
    slave_sel = 1'b1;
    write_byte(8'ha5);
    step(1);
    write_byte(8'h5a);
    chk({6'h00, sck_oe, mosi_oe}, 8'h03);
    chk({7'h00, flags.collision}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    n = 0;
    while (flags.done !== 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    // 16 half periods of four cycles each
    chk(8'(n >= 61 && n <= 65), 8'h01);
    chk(got, 8'ha5);
    chk({7'h00, irq}, 8'h01);
    write_byte(8'h77);
    step(12);
    chk(got, 8'ha5);
    clear_done();
    chk({4'h0, flags}, 8'h00);
    chk(data_rdata, 8'h3c);
    slave_sel = 1'b0;
  endtask
  // Soft select masks a low pin; then the pin faults the master
  task automatic t_fault();
    soft_mode = 1'b1;
    soft_level = 1'b1;
    ss_pin_n = 1'b0;
    step(6);
    chk({7'h00, flags.mode_fault}, 8'h00);
    soft_mode = 1'b0;
    step(6);
    chk({5'h00, flags.mode_fault, ctrl.enable, ctrl.master}, 8'h04);
    chk({7'h00, sck_oe}, 8'h00);
    ss_pin_n = 1'b1;
    step(3);
    status_read = 1'b1;
    step(1);
    status_read = 1'b0;
    cfg(8'h40);
    chk({7'h00, flags.mode_fault}, 8'h00);
  endtask
  // Enabled slave drives its data line only while selected; the bench
  // never clocks the slave, so no rate above CPU/2 reaches it
  task automatic t_slave();
    soft_mode = 1'b1;
    soft_level = 1'b0;
    step(4);
    chk({7'h00, miso_oe}, 8'h01);
    soft_level = 1'b1;
    step(4);
    chk({7'h00, miso_oe}, 8'h00);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    #3000000;
    errors++;
    close_out();
  end
  initial
  begin
    reset = 1'b1;
    {ctrl_write, status_read, data_write, data_read, slave_sel} = '0;
    {soft_mode, soft_level, ss_pin_n} = 3'b001;
    ctrl_wdata = '0;
    data_wdata = 8'h00;
    step(20);
    reset = 1'b0;
    t_reset();
    t_master();
    t_fault();
    t_slave();
    close_out();
  end
endmodule // test_spi_core_slave_select
`default_nettype wire

/* File: verilog/spi_core_pkg.sv */
// Shared constants and carrier types for the serial peripheral core
`default_nettype none
package spi_core_pkg;
  localparam logic [2:0] RESET_DIV_SEL = 3'h0;
  localparam int BITS_PER_BYTE = 8;
  localparam int DIV_COUNT_WIDTH = 8;
  // Half-period counts for the six master divisors; fastest is /4
  localparam logic [7:0] HALF_DIV0 = 8'h02;
  localparam logic [7:0] HALF_DIV1 = 8'h04;
  localparam logic [7:0] HALF_DIV2 = 8'h08;
  localparam logic [7:0] HALF_DIV3 = 8'h10;
  localparam logic [7:0] HALF_DIV4 = 8'h20;
  localparam logic [7:0] HALF_DIV5 = 8'h40;

  typedef struct packed {
    logic irq_enable;
    logic enable;
    logic master;
    logic polarity;
    logic phase;
    logic [2:0] div_sel;
  } ctrl_t;

  typedef struct packed {
    logic done;
    logic collision;
    logic overrun;
    logic mode_fault;
  } flags_t;
endpackage

`default_nettype wire

/* File: verilog/spi_core_slave_select.sv */
// Serial peripheral core with master/slave modes and slave select management
`timescale 1ns/1ps
`default_nettype none
module spi_core_slave_select
(
  input wire logic sys_clk,
  input wire logic reset,
  // Control writes from software
  input wire logic ctrl_write,
  input wire spi_core_pkg::ctrl_t ctrl_wdata,
  input wire logic slave_select_soft_mode,
  input wire logic slave_select_soft_level,
  // Status and data access strobes
  input wire logic status_read,
  input wire logic data_write,
  input wire logic data_read,
  input wire logic [7:0] data_wdata,
  // Status and data out
  output logic [7:0] data_rdata,
  output spi_core_pkg::flags_t flags,
  output spi_core_pkg::ctrl_t ctrl,
  output logic irq,
  // Pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_pin_n
);
  logic [1:0] sck_sync, mosi_sync, miso_sync, ss_sync;
  logic sck_prev, ss_prev_n, busy, status_seen, master_clk;
  logic [7:0] shifter, rx_buf, div_cnt;
  logic [3:0] edge_cnt;
  logic rx_bit, loaded, rx_latch;

  // Two-stage synchronisers on every pin input
  always_ff @(posedge sys_clk)
  begin
    sck_sync <= {sck_sync[0], sck_in};
    mosi_sync <= {mosi_sync[0], mosi_in};
    miso_sync <= {miso_sync[0], miso_in};
    ss_sync <= {ss_sync[0], ss_pin_n};
  end

  logic ss_int_n;
  assign ss_int_n = slave_select_soft_mode ? slave_select_soft_level
                                           : ss_sync[1];

  function automatic logic [7:0] half_div(input logic [2:0] sel);
    case (sel)
      3'h0: half_div = spi_core_pkg::HALF_DIV0;
      3'h1: half_div = spi_core_pkg::HALF_DIV1;
      3'h2: half_div = spi_core_pkg::HALF_DIV2;
      3'h3: half_div = spi_core_pkg::HALF_DIV3;
      3'h4: half_div = spi_core_pkg::HALF_DIV4;
      default: half_div = spi_core_pkg::HALF_DIV5;
    endcase
  endfunction

  logic is_master, is_slave_on, fault_now;
  assign is_master = ctrl.enable && ctrl.master;
  assign is_slave_on = ctrl.enable && !ctrl.master;
  assign fault_now = is_master && !ss_int_n;

  // Clock edge event: divider in master, synchronised pin in slave
  logic tick, slave_sck, lead_edge;
  assign slave_sck = sck_sync[1];
  assign tick = is_master ? (busy && div_cnt == 8'h01)
                          : (is_slave_on && !ss_int_n &&
                             slave_sck != sck_prev);
  // Leading edges are even-numbered (0,2,..); phase picks latch edge
  assign lead_edge = !edge_cnt[0];
  logic sample_now, shift_now;
  assign sample_now = tick && (lead_edge ^ ctrl.phase);
  assign shift_now = tick && !(lead_edge ^ ctrl.phase);
  // Tied data lines still work one way: only the driving end's oe is high
  assign rx_bit = ctrl.master ? miso_sync[1] : mosi_sync[1];

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sck_prev <= 1'b0;
    else
      sck_prev <= slave_sck;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ss_prev_n <= 1'b1;
    else
      ss_prev_n <= ss_int_n;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !busy || div_cnt == 8'h01)
      div_cnt <= half_div(ctrl.div_sel);
    else
      div_cnt <= div_cnt - 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      master_clk <= 1'b0;
    else if (!busy)
      master_clk <= ctrl.polarity;
    else if (is_master && tick)
      master_clk <= !master_clk;
  end

  // Transfer sequencing: master starts on write, slave on first clock
  logic byte_end, accept_write;
  assign byte_end = tick && edge_cnt == 4'hf;
  assign accept_write = data_write && !busy && !loaded &&
                        !(flags.done && !status_seen);
  always_ff @(posedge sys_clk)
  begin
    if (reset || !ctrl.enable)
      busy <= 1'b0;
    else if (byte_end)
      busy <= 1'b0;
    else if (is_master && accept_write)
      busy <= 1'b1;
    else if (is_slave_on && tick)
      busy <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !ctrl.enable || (!busy && !tick))
      edge_cnt <= 4'h0;
    else if (tick)
      edge_cnt <= edge_cnt + 4'h1;
  end

  // Slave shifter reload allowed once select rises between bytes
  always_ff @(posedge sys_clk)
  begin
    if (reset || byte_end)
      loaded <= 1'b0;
    else if (is_slave_on && !ctrl.phase && !ss_int_n && !busy &&
             data_write && edge_cnt == 4'h0 && ss_prev_n == 1'b0 && loaded)
      loaded <= 1'b1;
    else if (ss_int_n && !ss_prev_n)
      loaded <= 1'b0;
    else if (is_slave_on && !ctrl.phase && accept_write)
      loaded <= 1'b1;
  end

  // Sampled bit is held until the shift edge so the output bit stays
  // stable across the far end's sampling edge
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rx_latch <= 1'b0;
    else if (sample_now)
      rx_latch <= rx_bit;
  end

  // Second-edge phase puts the MSB out on edge 0, so no shift there
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      shifter <= 8'h00;
    else if (accept_write)
      shifter <= data_wdata;
    else if (shift_now && edge_cnt != 4'h0)
      shifter <= {shifter[6:0], rx_latch};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rx_buf <= 8'h00;
    else if (byte_end && !flags.done)
      rx_buf <= {shifter[6:0], ctrl.phase ? rx_bit : rx_latch};
  end
  assign data_rdata = rx_buf;

  // Clear sequence: status access while done, then data access
  always_ff @(posedge sys_clk)
  begin
    if (reset || !flags.done)
      status_seen <= 1'b0;
    else if (status_read)
      status_seen <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags.done <= 1'b0;
    else if (byte_end)
      flags.done <= 1'b1;
    else if (status_seen && (data_read || data_write))
      flags.done <= 1'b0;
  end

  // Collision: busy write, or first-edge slave without select toggle
  logic collide;
  assign collide = data_write && (busy || (is_slave_on && !ctrl.phase &&
                   loaded));
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags.collision <= 1'b0;
    else if (collide)
      flags.collision <= 1'b1;
    else if (status_seen && data_read)
      flags.collision <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags.overrun <= 1'b0;
    else if (byte_end && flags.done)
      flags.overrun <= 1'b1;
    else if (status_read)
      flags.overrun <= 1'b0;
  end

  logic fault_read;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fault_read <= 1'b0;
    else
      fault_read <= flags.mode_fault && (status_read || fault_read) &&
                    !ctrl_write;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags.mode_fault <= 1'b0;
    else if (fault_now)
      flags.mode_fault <= 1'b1;
    else if (fault_read && ctrl_write)
      flags.mode_fault <= 1'b0;
  end

  // Control: fault forces disabled slave; enable/master locked while faulted until status is read
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl <= '0;
      ctrl.div_sel <= spi_core_pkg::RESET_DIV_SEL;
    end
    else if (fault_now)
    begin
      ctrl.enable <= 1'b0;
      ctrl.master <= 1'b0;
    end
    else if (ctrl_write)
    begin
      ctrl <= ctrl_wdata;
      if (flags.mode_fault && !fault_read)
      begin
        ctrl.enable <= 1'b0;
        ctrl.master <= 1'b0;
      end
    end
  end

  assign irq = ctrl.irq_enable && (flags.done || flags.overrun ||
               flags.mode_fault);
  assign sck_out = master_clk;
  assign sck_oe = is_master;
  assign mosi_out = shifter[7];
  assign mosi_oe = is_master;
  assign miso_out = shifter[7];
  assign miso_oe = is_slave_on && !ss_int_n;

  chk_done_at_end: assert property (@(posedge sys_clk) disable iff (reset)
    byte_end |=> flags.done) else $error("done flag not set");
  chk_fault_drops: assert property (@(posedge sys_clk) disable iff (reset)
    fault_now |=> !ctrl.enable && !ctrl.master && flags.mode_fault)
    else $error("mode fault not handled");
  chk_busy_write_col: assert property (@(posedge sys_clk) disable iff (reset)
    data_write && busy |=> flags.collision && ($stable(shifter) || $past(tick)))
    else $error("collision not flagged");
  chk_overrun_keeps: assert property (@(posedge sys_clk) disable iff (reset)
    byte_end && flags.done |=> flags.overrun && $stable(rx_buf))
    else $error("overrun wrong");
  chk_soft_select: assert property (@(posedge sys_clk) disable iff (reset)
    slave_select_soft_mode |-> ss_int_n == slave_select_soft_level)
    else $error("soft select ignored");
  chk_sck_drive: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl.master |-> !sck_oe) else $error("sck driven as slave");
  chk_div_fast: assert property (@(posedge sys_clk) disable iff (reset)
    is_master && tick |-> ##1 !tick) else $error("clock too fast");
  chk_phase_shift: assert property (@(posedge sys_clk) disable iff (reset)
    sample_now |-> !shift_now) else $error("edge overlap");
endmodule // spi_core_slave_select
`default_nettype wire
